// *** rtl/crcgen_cfg.svh ***
`ifndef CRCGEN_CFG_SVH
`define CRCGEN_CFG_SVH
// Register offsets on the byte-wide register port.
`define CRCGEN_OFS_HIGH 1'h0
`define CRCGEN_OFS_LOW 1'h1
// Feedback polynomial x^16 + x^12 + x^5 + 1.
`define CRCGEN_POLY 16'h1021
// Shift register value after reset.
`define CRCGEN_RESET_VALUE 16'h0000
// Default FIFO depth in words.
`define CRCGEN_FIFO_DEPTH 8
`endif

// *** rtl/crcgen_pkg.sv ***
package crcgen_pkg;
  // Seeding progress; one-hot codes.
  typedef enum logic [1:0] {
    crcgen_idle = 2'h1,
    crcgen_seed_low = 2'h2
  } crcgen_seed_type;
endpackage

// *** rtl/crcgen_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "crcgen_cfg.svh"
// ********************************************************
// Data FIFO
// ********************************************************
module crcgen_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = `CRCGEN_FIFO_DEPTH
) (
  input wire logic clk_in, // Clock.
  input wire logic rst_n_in, // Async reset, active low.
  input wire logic in_valid_in, // Write word offered.
  output logic in_ready_out, // Room for a word.
  input wire logic [WIDTH-1:0] in_data_in, // Word written.
  output logic out_valid_out, // Word available.
  input wire logic out_ready_in, // Drain side takes word.
  output logic [WIDTH-1:0] out_data_out // Oldest word.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;

  // Flags come from the count so full and empty are exact.
  assign in_ready_out = (count != DEPTH[AW:0]);
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];

  // Storage is not reset; only pointers matter.
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // Pointer and count bookkeeping.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// *** rtl/crcgen_top.sv ***
// Operation
// - High register write loads seed bits 15-8 and arms seeding.
// - Next low write while armed loads bits 7-0, finishing seeding.
// - Later low writes are data bytes shifted in MSB first.
// - All eight shifts complete in the one clock that takes the queued write.
// - Reads return shift register bits 15-8 and 7-0 raw.
// - Each byte continues from the previous result.
// - High write at any time abandons the calculation and reseeds.
// - Direct non-augmented form of polynomial 0x1021.
// - No zero augmentation and no final inversion.
// - Seed is fully software programmable.
// - Message 123456789 gives 0x31c3 seed 0, 0x29b1 seed ffff.
// - Seed 0x1d0f matches augmented variant started at 0xffff.
// - Shallow stop pauses work; deeper stop recovers in reset state.
`timescale 1ns/1ps
`default_nettype none
`include "crcgen_cfg.svh"
// ********************************************************
// CRC16 byte generator
// ********************************************************
module crcgen_top
  import crcgen_pkg::*;
#(
  parameter int FIFO_DEPTH = `CRCGEN_FIFO_DEPTH
) (
  input wire logic core_clk_in, // 50 MHz clock.
  input wire logic arst_n_in, // Async reset, active low.
  input wire logic wr_en_in, // Register write strobe.
  input wire logic addr_in, // Register select: 0 high, 1 low.
  input wire logic [7:0] wr_data_in, // Write data.
  input wire logic stop_hold_in, // Shallow stop: pause work.
  output logic wr_ready_out, // Write can be taken.
  output logic [7:0] crc_result_high_out, // Result bits 15-8.
  output logic [7:0] crc_result_low_out, // Result bits 7-0.
  output logic busy_out // Writes still queued.
);
  // ******************************************************
  // Byte step
  // ******************************************************
  // Eight serial MSB-first steps unrolled into one clock.
  function automatic logic [15:0] crc_byte(input logic [15:0] crc,
                                           input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ data[i]) begin
        c = {c[14:0], 1'b0} ^ `CRCGEN_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  logic [15:0] shift_reg;
  crcgen_seed_type seed_state;
  crcgen_seed_type next_seed_state;
  logic [15:0] next_shift_reg;
  logic q_valid;
  logic q_ready;
  logic [8:0] q_data;
  logic fifo_ready;
  localparam int FW = $clog2(FIFO_DEPTH) + 1;
  logic [FW-1:0] fill;
  logic [FW-1:0] next_fill;

  // ******************************************************
  // Write queue
  // ******************************************************
  // Writes are queued so a held block loses none; ready pushes back.
  crcgen_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(core_clk_in),
    .rst_n_in(arst_n_in),
    .in_valid_in(wr_en_in),
    .in_ready_out(fifo_ready),
    .in_data_in({addr_in, wr_data_in}),
    .out_valid_out(q_valid),
    .out_ready_in(q_ready),
    .out_data_out(q_data)
  );

  // Shallow stop freezes the engine without losing state.
  assign q_ready = !stop_hold_in;
  wire take = q_valid && q_ready;
  wire is_high = (q_data[8] == `CRCGEN_OFS_HIGH);
  wire [7:0] byte_in = q_data[7:0];

  // Occupancy mirrors the queue count, so the registered ready and busy
  // flags describe the queue after this edge and never lag, except ready, which reset holds low until the first edge.
  wire push = wr_en_in && fifo_ready;
  assign next_fill = fill + FW'(push) - FW'(take);

  // Next state of the generator for the word being taken.
  always_comb begin
    next_seed_state = seed_state;
    next_shift_reg = shift_reg;
    if (take) begin
      if (is_high) begin
        next_shift_reg = {byte_in, shift_reg[7:0]};
        next_seed_state = crcgen_seed_low;
      end else if (seed_state == crcgen_seed_low) begin
        next_shift_reg = {shift_reg[15:8], byte_in};
        next_seed_state = crcgen_idle;
      end else begin
        next_shift_reg = crc_byte(shift_reg, byte_in);
      end
    end
  end

  // Generator state; deeper stops arrive here as a system reset.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      shift_reg <= `CRCGEN_RESET_VALUE;
      seed_state <= crcgen_idle;
      fill <= '0;
    end else begin
      shift_reg <= next_shift_reg;
      seed_state <= next_seed_state;
      fill <= next_fill;
    end
  end

  // Outputs from flops: results load from next_shift_reg, so they match the register with no lag.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      crc_result_high_out <= 8'h00;
      crc_result_low_out <= 8'h00;
      wr_ready_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      crc_result_high_out <= next_shift_reg[15:8];
      crc_result_low_out <= next_shift_reg[7:0];
      wr_ready_out <= (next_fill != FW'(FIFO_DEPTH));
      busy_out <= (next_fill != '0);
    end
  end
endmodule
`default_nettype wire

// *** bench/crcgen_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker
// ****
module crcgen_checker (
  input wire logic core_clk_in, // Clock.
  input wire logic arst_n_in, // Reset.
  input wire logic wr_en_in, // Strobe.
  input wire logic addr_in, // Select.
  input wire logic [7:0] wr_data_in, // Byte.
  input wire logic stop_hold_in, // Pause.
  input wire logic wr_ready_out, // Room.
  input wire logic [7:0] crc_result_high_out, // High.
  input wire logic [7:0] crc_result_low_out, // Low.
  input wire logic busy_out // Busy.
);
  logic armed;
  wire hw = wr_en_in && wr_ready_out && !addr_in;
  wire lw = wr_en_in && wr_ready_out && addr_in;
  wire [15:0] r = {crc_result_high_out, crc_result_low_out};
  // Bit-serial reference, so a one-clock design is held to MSB first.
  function automatic logic [15:0] step(logic [15:0] c, logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  // Seeding state, kept to tell seed bytes from data bytes.
  always_ff @(posedge core_clk_in or negedge arst_n_in)
    if (!arst_n_in) armed <= 1'b0;
    else if (wr_en_in && wr_ready_out) armed <= !addr_in;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence calm; (!stop_hold_in)[*8]; endsequence
  sequence quiet; !wr_en_in && !stop_hold_in; endsequence
  // Queue empty too, so the write under test was the last word taken.
  sequence drained; !wr_en_in && !stop_hold_in && !busy_out; endsequence
  a_high_seed: assert property (calm ##0 hw ##1 quiet ##1 drained |->
    ##1 crc_result_high_out == $past(wr_data_in, 3))
    else $error("high seed");
  a_low_seed: assert property (calm ##0 hw ##1 lw ##1 quiet
    ##1 drained |-> ##1
    r == {$past(wr_data_in, 4), $past(wr_data_in, 3)}) else $error("seed");
  a_data_shift: assert property (calm ##0 lw && !armed
    ##1 quiet ##1 drained |-> ##1
    r == step($past(r, 2), $past(wr_data_in, 3))) else $error("shift");
  a_result_hold: assert property (calm ##0 quiet ##1 drained |=>
    $stable(r)) else $error("hold");
  a_stop_pause: assert property (stop_hold_in[*4] |=> $stable(r))
    else $error("pause");
  a_reset_zero: assert property ($rose(arst_n_in) |-> r == 16'h0000)
    else $error("reset");
  a_room_calm: assert property (calm |-> wr_ready_out)
    else $error("room");
  a_ready_back: assert property ($fell(stop_hold_in) |-> ##[1:3] wr_ready_out)
    else $error("ready");
endmodule
bind crcgen_top crcgen_checker chk (.core_clk_in(core_clk_in),
  .arst_n_in(arst_n_in), .wr_en_in(wr_en_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .stop_hold_in(stop_hold_in),
  .wr_ready_out(wr_ready_out), .crc_result_high_out(crc_result_high_out),
  .crc_result_low_out(crc_result_low_out), .busy_out(busy_out));
`default_nettype wire

// *** bench/crcgen_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module crcgen_top_bench;
  logic clk = 0, rst_n = 0, we = 0, a = 0, hold = 0;
  logic [7:0] d = 8'h00;
  wire ready, busy;
  wire [7:0] hi, lo;
  int n_mismatch = 0, checked = 0;
  crcgen_top dut (.core_clk_in(clk), .arst_n_in(rst_n), .wr_en_in(we),
    .addr_in(a), .wr_data_in(d), .stop_hold_in(hold), .wr_ready_out(ready),
    .crc_result_high_out(hi), .crc_result_low_out(lo), .busy_out(busy));
  // Clock of 20 ns.
  initial forever #10 clk = ~clk;
  task automatic cmp(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // Writes wait for room; the strobe is left up for back-to-back use.
  task automatic wr(logic sel, logic [7:0] v);
    @(negedge clk);
    while (ready !== 1'b1) @(negedge clk);
    we = 1;
    a = sel;
    d = v;
  endtask
  task automatic idle(int n);
    @(negedge clk);
    we = 0;
    repeat (n) @(negedge clk);
  endtask
  task automatic bytes(string m);
    foreach (m[i]) wr(1, m[i]);
  endtask
  task automatic t_vec(logic [15:0] s, string m, logic [15:0] e);
    wr(0, s[15:8]);
    wr(1, s[7:0]);
    idle(3);
    cmp("seed", {hi, lo}, s);
    bytes(m);
    idle(3);
    cmp("crc", {hi, lo}, e);
  endtask
  task automatic t_reset;
    cmp("reset", {hi, lo}, 16'h0000);
    wr(1, 8'h41);
    idle(3);
    cmp("unseeded", {hi, lo}, 16'h58e5);
    wr(0, 8'ha5);
    idle(3);
    cmp("high", {hi, lo}, 16'ha5e5);
  endtask
  // A reseed lands right after data bytes, with no gap.
  task automatic t_abort;
    wr(0, 8'h00);
    wr(1, 8'h00);
    bytes("12");
    wr(0, 8'hff);
    wr(1, 8'hff);
    bytes("A");
    idle(3);
    cmp("abort", {hi, lo}, 16'hb915);
  endtask
  // Paused work fills the queue until refused, then resumes intact.
  task automatic t_stop;
    @(negedge clk);
    hold = 1;
    wr(0, 8'h00);
    wr(1, 8'h00);
    bytes("123456");
    idle(2);
    cmp("full", {15'h0000, ready}, 16'h0000);
    cmp("queued", {15'h0000, busy}, 16'h0001);
    hold = 0;
    bytes("789");
    idle(12);
    cmp("resume", {hi, lo}, 16'h31c3);
    cmp("drained", {15'h0000, busy}, 16'h0000);
    // A deep stop in mid-seed must drop the armed seeding state.
    wr(0, 8'h12);
    idle(3);
    rst_n = 0;
    idle(2);
    cmp("deep", {hi, lo}, 16'h0000);
    rst_n = 1;
    wr(1, 8'h41);
    idle(3);
    cmp("rearm", {hi, lo}, 16'h58e5);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1;
    t_reset();
    t_vec(16'h0000, "123456789", 16'h31c3);
    t_vec(16'hffff, "123456789", 16'h29b1);
    t_vec(16'h1d0f, "123456789", 16'he5cc);
    t_abort();
    t_stop();
    complete_run();
  end
  // Cuts a hang short after far more than the run needs.
  initial begin
    #40000;
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
